// >>> design/fdci_pkg.sv
// Shared constants for the drive control link: timing, track range, idle levels.
// Assumes a single 50 MHz system clock at both ends of the link.
package fdci_pkg;

  // System clock
  localparam int CLK_MHZ = 50;

  // Select to valid, ns
  localparam int SEL_VALID_NS  = 500;
  localparam int SEL_VALID_CYC = (SEL_VALID_NS * CLK_MHZ) / 1000;

  // Spindle spin-up, ms
  localparam int SPIN_UP_MS  = 480;
  localparam int SPIN_UP_CYC = SPIN_UP_MS * CLK_MHZ * 1000;

  // Step pulse low width and direction setup, ns
  localparam int STEP_LOW_NS  = 800;
  localparam int STEP_LOW_CYC = (STEP_LOW_NS * CLK_MHZ + 999) / 1000;

  // Seek and settle, ms
  localparam int SEEK_MS  = 18;
  localparam int SEEK_CYC = SEEK_MS * CLK_MHZ * 1000;

  // Step spacing, ms
  localparam int STEP_SAME_MS  = 3;
  localparam int STEP_SAME_CYC = STEP_SAME_MS * CLK_MHZ * 1000;
  localparam int STEP_REV_MS   = 4;
  localparam int STEP_REV_CYC  = STEP_REV_MS * CLK_MHZ * 1000;

  // Head side settle, us
  localparam int SIDE_SETTLE_US  = 100;
  localparam int SIDE_SETTLE_CYC = SIDE_SETTLE_US * CLK_MHZ;

  // Quiet time after write gate drops, us
  localparam int WG_HOLD_US  = 650;
  localparam int WG_HOLD_CYC = WG_HOLD_US * CLK_MHZ;

  // Write data pulse low width, ns
  localparam int WD_LOW_MIN_NS  = 100;
  localparam int WD_LOW_MAX_NS  = 1100;
  localparam int WD_LOW_CYC     = (WD_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WD_LOW_MAX_CYC = (WD_LOW_MAX_NS * CLK_MHZ) / 1000;

  // Track-zero valid after step, us
  localparam int TZ_VALID_US = 2800;

  // Track range
  localparam int               TRACK_W    = 7;
  localparam int               LAST_TRACK = 81;
  localparam logic [TRACK_W-1:0] TRACK_RST = 7'h00;

  // Idle levels of synchronised host pins {sel,motor,dir,step,gate,wdata,side}
  localparam int       DRV_IN_W   = 7;
  localparam logic [6:0] DRV_IN_IDLE = 7'h7f;
  // Idle levels of synchronised drive pins {trackZero,writeProt,diskChg}
  localparam int       HOST_IN_W   = 3;
  localparam logic [2:0] HOST_IN_IDLE = 3'h7;

endpackage

// >>> design/fdci_if.sv
// Link between host controller and drive: host pins plus open-collector returns.
// The wire level of each open-collector line is resolved here, pulled high when idle.
`timescale 1ns/1ns
`default_nettype none
interface fdci_if;
  logic unitSel_n;
  logic motorOn_n;
  logic stepOut;
  logic step_n;
  logic writeGate_n;
  logic writeData_n;
  logic sideZero;
  logic trackZeroOut;
  logic trackZeroOe;
  logic writeProtOut;
  logic writeProtOe;
  logic diskChgOut;
  logic diskChgOe;
  wire  trackZero_n;
  wire  writeProt_n;
  wire  diskChg_n;

  // Pull-up unless the drive sinks the line
  assign trackZero_n = trackZeroOe ? trackZeroOut : 1'b1;
  assign writeProt_n = writeProtOe ? writeProtOut : 1'b1;
  assign diskChg_n   = diskChgOe   ? diskChgOut   : 1'b1;

  modport drive (
    input  unitSel_n, motorOn_n, stepOut, step_n, writeGate_n, writeData_n, sideZero,
    output trackZeroOut, trackZeroOe, writeProtOut, writeProtOe, diskChgOut, diskChgOe
  );
  modport host (
    output unitSel_n, motorOn_n, stepOut, step_n, writeGate_n, writeData_n, sideZero,
    input  trackZero_n, writeProt_n, diskChg_n
  );
endinterface
`default_nettype wire

// >>> design/fdci_drive.sv
// Drive end of the control link: select, spindle, stepping, write gate, write data.
// Assumes host pins arrive asynchronously; disk sensors come from logic on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module fdci_drive
  import fdci_pkg::*;
#(
  parameter int MOTOR_CYC = SPIN_UP_CYC,
  parameter int SEEK_TIME = SEEK_CYC,
  parameter int SIDE_TIME = SIDE_SETTLE_CYC,
  parameter int HOLD_TIME = WG_HOLD_CYC,
  parameter int MAX_TRACK = LAST_TRACK
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  fdci_if.drive                   link,
  input  wire logic               diskPresent,
  input  wire logic               diskWriteInhibit,
  output logic                    selected,
  output logic                    spindleAtSpeed,
  output logic [TRACK_W-1:0]      headTrack,
  output logic                    headMoving,
  output logic                    stepAccepted,
  output logic                    writeMode,
  output logic                    bitEvent,
  output logic                    upperSide,
  output logic                    readValid,
  output logic                    diskChanged
);

  localparam int MOT_W  = $clog2(MOTOR_CYC + 1);
  localparam int SEEK_W = $clog2(SEEK_TIME + 1);
  localparam int SIDE_W = $clog2(SIDE_TIME + 1);
  localparam int HOLD_W = $clog2(HOLD_TIME + 1);

  logic [DRV_IN_W-1:0] pinRaw;
  logic [DRV_IN_W-1:0] pinMeta;
  logic [DRV_IN_W-1:0] pinSync;
  logic                selNow;
  logic                motorNow;
  logic                dirOutNow;
  logic                stepLvl;
  logic                gateNow;
  logic                wdLvl;
  logic                sideNow;
  logic                stepPrev;
  logic                wdPrev;
  logic                sidePrev;
  logic                gatePrev;
  logic                diskPrev;
  logic                stepEdge;
  logic                stepIgnore;
  logic                atZero;
  logic                trackZeroFlag;
  logic [MOT_W-1:0]    motorCnt;
  logic [SEEK_W-1:0]   seekCnt;
  logic [SIDE_W-1:0]   sideCnt;
  logic [HOLD_W-1:0]   holdCnt;

  assign pinRaw = {link.unitSel_n, link.motorOn_n, link.stepOut, link.step_n,
                   link.writeGate_n, link.writeData_n, link.sideZero};

  // Two-stage synchroniser per pin
  for (genvar i = 0; i < DRV_IN_W; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pinMeta[i] <= DRV_IN_IDLE[i];
        pinSync[i] <= DRV_IN_IDLE[i];
      end else begin
        pinMeta[i] <= pinRaw[i];
        pinSync[i] <= pinMeta[i];
      end
    end
  end

  assign selNow    = ~pinSync[6];
  assign motorNow  = ~pinSync[5];
  assign dirOutNow = pinSync[4];
  assign stepLvl   = pinSync[3];
  assign gateNow   = ~pinSync[2];
  assign wdLvl     = pinSync[1];
  assign sideNow   = pinSync[0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stepPrev <= 1'b1;
      wdPrev   <= 1'b1;
      sidePrev <= 1'b1;
      gatePrev <= 1'b0;
      diskPrev <= 1'b0;
    end else begin
      stepPrev <= stepLvl;
      wdPrev   <= wdLvl;
      sidePrev <= sideNow;
      gatePrev <= gateNow;
      diskPrev <= diskPresent;
    end
  end

  assign atZero   = (headTrack == TRACK_RST);
  // Trailing edge of step is the rising edge of the low pulse
  assign stepEdge = selNow & stepLvl & ~stepPrev;
  assign stepIgnore = (gateNow & ~diskWriteInhibit)
                    | (atZero & dirOutNow)
                    | (~dirOutNow & (headTrack == TRACK_W'(MAX_TRACK)));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      selected <= 1'b0;
    end else begin
      selected <= selNow;
    end
  end

  // Spindle runs on motor request alone, select not needed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      motorCnt       <= '0;
      spindleAtSpeed <= 1'b0;
    end else if (!motorNow) begin
      motorCnt       <= '0;
      spindleAtSpeed <= 1'b0;
    end else if (motorCnt == MOT_W'(MOTOR_CYC)) begin
      spindleAtSpeed <= 1'b1;
    end else begin
      motorCnt <= motorCnt + 1'b1;
    end
  end

  // Head position, one track per accepted step
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      headTrack    <= TRACK_RST;
      stepAccepted <= 1'b0;
    end else begin
      stepAccepted <= stepEdge & ~stepIgnore;
      if (stepEdge && !stepIgnore) begin
        if (dirOutNow) begin
          headTrack <= headTrack - 1'b1;
        end else begin
          headTrack <= headTrack + 1'b1;
        end
      end
    end
  end

  // Seek and settle timer from trailing edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seekCnt <= '0;
    end else if (stepEdge && !stepIgnore) begin
      seekCnt <= SEEK_W'(SEEK_TIME);
    end else if (seekCnt != '0) begin
      seekCnt <= seekCnt - 1'b1;
    end
  end

  assign headMoving = (seekCnt != '0);

  // Track position updates at the step; the indication is registered from it, so it trails the move by a cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trackZeroFlag <= 1'b1;
    end else begin
      trackZeroFlag <= atZero;
    end
  end

  // Write mode and write data edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      writeMode <= 1'b0;
      bitEvent  <= 1'b0;
    end else begin
      writeMode <= selNow & gateNow & ~diskWriteInhibit;
      bitEvent  <= selNow & gateNow & ~diskWriteInhibit & wdPrev & ~wdLvl;
    end
  end

  // Side select and read settle timers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      upperSide <= 1'b0;
      sideCnt   <= '0;
    end else begin
      upperSide <= ~sideNow;
      if (sideNow != sidePrev) begin
        sideCnt <= SIDE_W'(SIDE_TIME);
      end else if (sideCnt != '0) begin
        sideCnt <= sideCnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdCnt <= '0;
    end else if (gatePrev && !gateNow) begin
      holdCnt <= HOLD_W'(HOLD_TIME);
    end else if (holdCnt != '0) begin
      holdCnt <= holdCnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readValid <= 1'b0;
    end else begin
      readValid <= selNow & spindleAtSpeed & ~gateNow & (seekCnt == '0)
                 & (sideCnt == '0) & (holdCnt == '0);
    end
  end

  // Disk change: removal sets and wins over a clearing step
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diskChanged <= 1'b1;
    end else if (diskPrev && !diskPresent) begin
      diskChanged <= 1'b1;
    end else if (diskPresent && stepEdge) begin
      diskChanged <= 1'b0;
    end
  end

  // Open-collector returns sink only while selected
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.trackZeroOe <= 1'b0;
      link.writeProtOe <= 1'b0;
      link.diskChgOe   <= 1'b0;
    end else begin
      link.trackZeroOe <= selNow & trackZeroFlag;
      link.writeProtOe <= selNow & diskWriteInhibit;
      link.diskChgOe   <= selNow & diskChanged;
    end
  end

  assign link.trackZeroOut = 1'b0;
  assign link.writeProtOut = 1'b0;
  assign link.diskChgOut   = 1'b0;

endmodule
`default_nettype wire

// >>> design/fdci_host.sv
// Host end of the control link: drives select, motor, side, step, gate and data.
// Assumes user requests come from logic on clk_sys; drive returns are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module fdci_host
  import fdci_pkg::*;
#(
  parameter int SAME_TIME = STEP_SAME_CYC,
  parameter int REV_TIME  = STEP_REV_CYC,
  parameter int SEEK_TIME = SEEK_CYC,
  parameter int SIDE_TIME = SIDE_SETTLE_CYC,
  parameter int HOLD_TIME = WG_HOLD_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  fdci_if.host      link,
  input  wire logic selectReq,
  input  wire logic motorReq,
  input  wire logic upperReq,
  input  wire logic stepValid,
  input  wire logic stepOutward,
  output logic      stepReady,
  input  wire logic gateReq,
  output logic      gateOn,
  input  wire logic bitValid,
  output logic      bitReady,
  output logic      trackZero,
  output logic      writeProtected,
  output logic      diskChanged
);

  localparam int TMR_W = $clog2(SEEK_TIME + REV_TIME + SIDE_TIME + HOLD_TIME + 1);

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_STEP  = 2'b01,
    H_WDATA = 2'b10
  } fdci_hst_e;

  fdci_hst_e            state;
  logic [HOST_IN_W-1:0] inRaw;
  logic [HOST_IN_W-1:0] inMeta;
  logic [HOST_IN_W-1:0] inSync;
  logic [TMR_W-1:0]     sinceStep;
  logic [TMR_W-1:0]     sinceSide;
  logic [TMR_W-1:0]     sinceGate;
  logic [5:0]           pulseCnt;
  logic                 lastOut;
  logic                 quiet;
  logic                 spacingOk;

  assign inRaw = {link.trackZero_n, link.writeProt_n, link.diskChg_n};

  for (genvar i = 0; i < HOST_IN_W; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        inMeta[i] <= HOST_IN_IDLE[i];
        inSync[i] <= HOST_IN_IDLE[i];
      end else begin
        inMeta[i] <= inRaw[i];
        inSync[i] <= inMeta[i];
      end
    end
  end

  assign trackZero      = ~inSync[2];
  assign writeProtected = ~inSync[1];
  assign diskChanged    = ~inSync[0];

  assign gateOn    = ~link.writeGate_n;
  assign quiet     = (link.writeGate_n == 1'b1) && (sinceGate >= TMR_W'(HOLD_TIME));
  assign spacingOk = (stepOutward == lastOut) ? (sinceStep >= TMR_W'(SAME_TIME))
                                              : (sinceStep >= TMR_W'(REV_TIME));
  assign stepReady = (state == H_IDLE) && !link.unitSel_n && quiet && spacingOk;
  assign bitReady  = (state == H_IDLE) && gateOn;

  // Saturating interval timers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sinceStep <= TMR_W'(REV_TIME);
      sinceSide <= TMR_W'(SIDE_TIME);
      sinceGate <= TMR_W'(HOLD_TIME);
    end else begin
      if (state == H_STEP && pulseCnt == 6'h01) begin
        sinceStep <= '0;
      end else if (sinceStep < TMR_W'(SEEK_TIME)) begin
        sinceStep <= sinceStep + 1'b1;
      end
      if (quiet && (link.sideZero == upperReq)) begin
        sinceSide <= '0;
      end else if (sinceSide < TMR_W'(SIDE_TIME)) begin
        sinceSide <= sinceSide + 1'b1;
      end
      if (gateOn && !gateReq && state == H_IDLE) begin
        sinceGate <= '0;
      end else if (sinceGate < TMR_W'(HOLD_TIME)) begin
        sinceGate <= sinceGate + 1'b1;
      end
    end
  end

  // Level pins change only after the post-write quiet time
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.unitSel_n <= 1'b1;
      link.motorOn_n <= 1'b1;
      link.sideZero  <= 1'b1;
    end else if (quiet) begin
      link.unitSel_n <= ~selectReq;
      link.motorOn_n <= ~motorReq;
      link.sideZero  <= ~upperReq;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.writeGate_n <= 1'b1;
    end else if (!gateOn && gateReq && state == H_IDLE && !link.unitSel_n
                 && sinceStep >= TMR_W'(SEEK_TIME) && sinceSide >= TMR_W'(SIDE_TIME)) begin
      link.writeGate_n <= 1'b0;
    end else if (gateOn && !gateReq && state == H_IDLE) begin
      link.writeGate_n <= 1'b1;
    end
  end

  // Step and write-data pulse generator
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state            <= H_IDLE;
      pulseCnt         <= '0;
      lastOut          <= 1'b1;
      link.stepOut     <= 1'b1;
      link.step_n      <= 1'b1;
      link.writeData_n <= 1'b1;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (stepValid && stepReady) begin
            link.stepOut <= stepOutward;
            link.step_n  <= 1'b0;
            pulseCnt     <= 6'(STEP_LOW_CYC);
            state        <= H_STEP;
          end else if (bitValid && bitReady) begin
            link.writeData_n <= 1'b0;
            pulseCnt         <= 6'(WD_LOW_CYC);
            state            <= H_WDATA;
          end
        end
        H_STEP: begin
          pulseCnt <= pulseCnt - 1'b1;
          if (pulseCnt == 6'h01) begin
            link.step_n <= 1'b1;
            lastOut     <= link.stepOut;
            state       <= H_IDLE;
          end
        end
        H_WDATA: begin
          pulseCnt <= pulseCnt - 1'b1;
          if (pulseCnt == 6'h01) begin
            link.writeData_n <= 1'b1;
            state            <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> sim/fdci_sva.sv
// Checker for the wires between host and drive ends.
// Assumes the shortened timer values used by the bench.
`timescale 1ns/1ns
`default_nettype none
module fdci_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic unitSel_n,
  input wire logic motorOn_n,
  input wire logic stepOut,
  input wire logic step_n,
  input wire logic writeGate_n,
  input wire logic writeData_n,
  input wire logic sideZero,
  input wire logic trackZeroOut,
  input wire logic trackZeroOe,
  input wire logic writeProtOe,
  input wire logic diskChgOe
);
  logic [7:0] quietCnt;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Cycles since write gate dropped, saturating
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      quietCnt <= 8'hff;
    end else if (!writeGate_n) begin
      quietCnt <= 8'h00;
    end else if (quietCnt != 8'hff) begin
      quietCnt <= quietCnt + 8'h01;
    end
  end

  a_step_width: assert property ($fell(step_n) |-> ##40 $rose(step_n))
    else $error("step pulse width wrong");
  a_dir_setup: assert property (!step_n && !$past(step_n) |-> $stable(stepOut))
    else $error("direction moved during step");
  a_step_spacing: assert property ($rose(step_n) |-> not (##[1:59] $fell(step_n)))
    else $error("steps too close");
  a_gate_seek: assert property ($rose(step_n) |-> not (##[0:298] $fell(writeGate_n)))
    else $error("gate too soon after step");
  a_gate_side: assert property ($changed(sideZero) |-> not (##[0:48] $fell(writeGate_n)))
    else $error("gate too soon after side change");
  a_quiet_hold: assert property (writeGate_n && quietCnt < 8'd78 |->
    $stable(unitSel_n) && $stable(motorOn_n) && $stable(sideZero) && !$fell(step_n))
    else $error("link changed after gate drop");
  a_wd_width: assert property ($fell(writeData_n) |=> !writeData_n [*4] ##1 writeData_n)
    else $error("write pulse width wrong");
  a_wd_gated: assert property ($fell(writeData_n) |-> !writeGate_n)
    else $error("write pulse without gate");
  a_sink_low: assert property (trackZeroOe |-> !trackZeroOut && !$past(unitSel_n, 3))
    else $error("return line not driven low");
  a_desel_release: assert property ($rose(unitSel_n) |->
    ##25 (unitSel_n -> !(trackZeroOe || writeProtOe || diskChgOe)))
    else $error("returns held while deselected");

  c_step_out: cover property ($rose(step_n) && stepOut);
  c_gate_on: cover property ($fell(writeGate_n));
  c_bit_sent: cover property ($fell(writeData_n));
endmodule
`default_nettype wire

// >>> sim/fdci_bench.sv
// Self-checking bench: host end and drive end joined by the link.
// Assumes shortened timers; disk sensors driven by the bench.
`timescale 1ns/1ns
`default_nettype none
module fdci_bench;
  import fdci_pkg::*;
  logic               clk_sys, rst, diskPresent, diskWriteInhibit;
  logic               selectReq, motorReq, upperReq, stepValid, stepOutward, gateReq, bitValid;
  logic               stepReady, gateOn, bitReady, trackZero, writeProtected, hDiskChg;
  logic               selected, spindleAtSpeed, headMoving, stepAccepted, writeMode;
  logic               bitEvent, upperSide, readValid, dDiskChg;
  logic [TRACK_W-1:0] headTrack;
  int                 failures, compares, seed, trk, n, k, ev, t;

  // Shortened timers; seek, side and hold are shared by both ends so their intervals agree
  localparam int MOT_T  = 200;
  localparam int SAME_T = 100;
  localparam int REV_T  = 150;
  localparam int SEEK_T = 300;
  localparam int SIDE_T = 50;
  localparam int HOLD_T = 80;

  fdci_if lnk();
  fdci_host #(
    .SAME_TIME(SAME_T),
    .REV_TIME(REV_T),
    .SEEK_TIME(SEEK_T),
    .SIDE_TIME(SIDE_T),
    .HOLD_TIME(HOLD_T)
  ) u_fdci_host (
    .clk_sys(clk_sys), .rst(rst), .link(lnk.host), .selectReq(selectReq), .motorReq(motorReq),
    .upperReq(upperReq), .stepValid(stepValid), .stepOutward(stepOutward), .stepReady(stepReady),
    .gateReq(gateReq), .gateOn(gateOn), .bitValid(bitValid), .bitReady(bitReady), .trackZero(trackZero),
    .writeProtected(writeProtected), .diskChanged(hDiskChg));
  fdci_drive #(
    .MOTOR_CYC(MOT_T),
    .SEEK_TIME(SEEK_T),
    .SIDE_TIME(SIDE_T),
    .HOLD_TIME(HOLD_T)
  ) u_fdci_drive (
    .clk_sys(clk_sys), .rst(rst), .link(lnk.drive), .diskPresent(diskPresent),
    .diskWriteInhibit(diskWriteInhibit), .selected(selected), .spindleAtSpeed(spindleAtSpeed),
    .headTrack(headTrack), .headMoving(headMoving), .stepAccepted(stepAccepted), .writeMode(writeMode),
    .bitEvent(bitEvent), .upperSide(upperSide), .readValid(readValid), .diskChanged(dDiskChg));
  fdci_sva u_fdci_sva (
    .clk_sys(clk_sys), .rst(rst), .unitSel_n(lnk.unitSel_n), .motorOn_n(lnk.motorOn_n),
    .stepOut(lnk.stepOut), .step_n(lnk.step_n), .writeGate_n(lnk.writeGate_n),
    .writeData_n(lnk.writeData_n), .sideZero(lnk.sideZero), .trackZeroOut(lnk.trackZeroOut),
    .trackZeroOe(lnk.trackZeroOe), .writeProtOe(lnk.writeProtOe), .diskChgOe(lnk.diskChgOe));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_trk(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Step is taken unless it would leave the track range
  function automatic logic step_ok(input logic dir, input int cur);
    return dir ? (cur != 0) : (cur != LAST_TRACK);
  endfunction

  // Bits reach the disk only when it is writable
  function automatic int exp_bits(input int sent, input logic inh);
    return inh ? 0 : sent;
  endfunction

  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  // One step request; model track follows accepted moves
  task automatic step(input logic dir);
    logic ok;
    ok = step_ok(dir, trk);
    @(posedge clk_sys);
    stepOutward <= dir;
    stepValid   <= 1'b1;
    t = 0;
    do begin @(negedge clk_sys); t++; end while (stepReady !== 1'b1 && t < 500);
    if (t >= 500) failures++;
    @(posedge clk_sys);
    stepValid <= 1'b0;
    k = 0;
    repeat (50) begin @(negedge clk_sys); if (stepAccepted === 1'b1) k++; end
    if (ok) trk = dir ? trk - 1 : trk + 1;
    chk_bit(k == 1, ok);
    chk_trk(headTrack, 7'(trk));
    chk_bit(trackZero, trk == 0);
    if (ok) chk_bit(headMoving, 1'b1);
  endtask

  // Gate on, a random burst of bits, gate off
  task automatic wr(input logic inh);
    @(posedge clk_sys);
    diskWriteInhibit <= inh;
    cyc(20);
    @(posedge clk_sys);
    gateReq <= 1'b1;
    t = 0;
    do begin @(negedge clk_sys); t++; end while (gateOn !== 1'b1 && t < 600);
    if (t >= 600) failures++;
    cyc(4);
    chk_bit(writeMode, !inh);
    chk_bit(writeProtected, inh);
    n = 1 + ($random(seed) & 15);
    @(posedge clk_sys);
    bitValid <= 1'b1;
    k = 0;
    ev = 0;
    t = 0;
    while (k < n && t < 2000) begin
      @(negedge clk_sys);
      t++;
      if (bitReady === 1'b1) k++;
      if (bitEvent === 1'b1) ev++;
    end
    @(posedge clk_sys);
    bitValid <= 1'b0;
    repeat (8) begin @(negedge clk_sys); if (bitEvent === 1'b1) ev++; end
    chk_trk(7'(ev), 7'(exp_bits(n, inh)));
    @(posedge clk_sys);
    gateReq <= 1'b0;
    cyc(100);
    chk_bit(writeMode, 1'b0);
    $display("test write inh=%0d done", inh);
  endtask

  initial begin
    seed = 38;
    failures = 0;
    compares = 0;
    trk = 0;
    rst = 1'b1;
    diskPresent = 1'b1;
    diskWriteInhibit = 1'b0;
    {selectReq, motorReq, upperReq, stepValid, stepOutward, gateReq, bitValid} = 7'h00;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(2);
    chk_bit(dDiskChg, 1'b1);
    chk_trk(headTrack, 7'h00);
    $display("test reset done");
    @(posedge clk_sys);
    selectReq <= 1'b1;
    motorReq  <= 1'b1;
    t = 0;
    do begin @(negedge clk_sys); t++; end while (spindleAtSpeed !== 1'b1 && t < 400);
    chk_bit(t >= MOT_T && t <= MOT_T + 10, 1'b1);
    $display("test spinup done");
    chk_bit(hDiskChg, 1'b1);
    step(1'b1);
    chk_bit(dDiskChg, 1'b0);
    repeat (82) step(1'b0);
    repeat (20) step(1'($random(seed)));
    $display("test seek done");
    wr(1'b0);
    wr(1'b1);
    @(posedge clk_sys);
    upperReq <= 1'b1;
    cyc(8);
    chk_bit(upperSide, 1'b1);
    chk_bit(readValid, 1'b0);
    cyc(100);
    chk_bit(readValid, 1'b1);
    $display("test side done");
    @(posedge clk_sys);
    diskPresent <= 1'b0;
    cyc(10);
    chk_bit(dDiskChg, 1'b1);
    chk_bit(hDiskChg, 1'b1);
    @(posedge clk_sys);
    selectReq <= 1'b0;
    cyc(40);
    chk_bit(selected, 1'b0);
    chk_bit(hDiskChg, 1'b0);
    $display("test deselect done");
    end_sim;
  end

  // Hang guard, well past the expected run length
  initial begin
    #800000;
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
